// file: rtl/xpoint_cfg.svh
// register map, field positions, reset values and timing for the crosspoint setup port
`ifndef XPOINT_CFG_SVH
`define XPOINT_CFG_SVH

// printed register indices; byte address is four times the index
`define XP_IDX_CTRL      8'h20
`define XP_IDX_STATUS    8'h21
`define XP_IDX_READBACK  8'h22
`define XP_IDX_WRITE     8'h23
`define XP_ADDR_SHIFT    2

`define XP_REQ_NONE      2'h0
`define XP_REQ_WRITE     2'h1
`define XP_REQ_LSB       0
`define XP_REQ_MSB       1
`define XP_RDY_BIT       0
`define XP_OUT_SEL_LSB   4
`define XP_OUT_SEL_MSB   5
`define XP_IN_SEL_LSB    0
`define XP_IN_SEL_MSB    1
`define XP_SEL_W         2
`define XP_SEL_ZERO      2'h0
`define XP_ROUTE_RESET   8'h00
`define XP_WORD_ZERO     32'h0000_0000

// serial link timing
`define XP_SCLK_HALF_NS  40
`define XP_CLK_PERIOD_NS 10
`define XP_FRAME_BITS    4

`endif

// file: rtl/xpoint_pkg.sv
// types shared by the crosspoint setup port
package xpoint_pkg;

    typedef logic [1:0] sel_t;

    typedef struct packed {
        sel_t out_sel;
        sel_t in_sel;
    } route_cmd_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef enum logic [1:0] {
        SH_IDLE  = 2'b00,
        SH_SHIFT = 2'b01,
        SH_LOAD  = 2'b10
    } shift_state_e;

endpackage

// file: rtl/route_shifter.sv
// serial shifter that sends one output/input pair to the switch chip
`timescale 1ns/100ps
`include "xpoint_cfg.svh"

module route_shifter #(
    parameter int HALF_CYCLES = (`XP_SCLK_HALF_NS + `XP_CLK_PERIOD_NS - 1) / `XP_CLK_PERIOD_NS
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   ce,
    input  wire logic                   start,
    input  wire xpoint_pkg::route_cmd_s cmd,
    output logic                        busy,
    output logic                        done,
    output logic                        sw_sclk,
    output logic                        sw_sdata,
    output logic                        sw_load
);
    import xpoint_pkg::*;

    localparam int CW = $clog2(HALF_CYCLES + 1);

    shift_state_e                 state_q;
    logic [CW-1:0]                div_q;
    logic [2:0]                   bit_q;
    logic [`XP_FRAME_BITS-1:0]    sr_q;
    logic                         phase_q;

    wire half_end = (div_q == CW'(HALF_CYCLES - 1));
    wire last_bit = (bit_q == 3'(`XP_FRAME_BITS - 1));

    assign busy = (state_q != SH_IDLE);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q  <= SH_IDLE;
            div_q    <= '0;
            bit_q    <= '0;
            sr_q     <= '0;
            phase_q  <= 1'b0;
            done     <= 1'b0;
            sw_sclk  <= 1'b0;
            sw_sdata <= 1'b0;
            sw_load  <= 1'b0;
        end else if (ce) begin
            done  <= 1'b0;
            div_q <= half_end ? '0 : div_q + CW'(1);
            case (state_q)
                SH_IDLE: begin
                    div_q <= '0;
                    if (start) begin
                        sr_q     <= cmd;
                        sw_sdata <= cmd[`XP_FRAME_BITS-1];
                        bit_q    <= '0;
                        phase_q  <= 1'b0;
                        state_q  <= SH_SHIFT;
                    end
                end
                SH_SHIFT: begin
                    // data changes on the falling edge, chip samples on the rising
                    if (half_end) begin
                        phase_q <= ~phase_q;
                        sw_sclk <= ~phase_q;
                        if (phase_q) begin
                            sr_q     <= {sr_q[`XP_FRAME_BITS-2:0], 1'b0};
                            sw_sdata <= sr_q[`XP_FRAME_BITS-2];
                            bit_q    <= bit_q + 3'(1);
                            if (last_bit) begin
                                sw_load <= 1'b1;
                                state_q <= SH_LOAD;
                            end
                        end
                    end
                end
                SH_LOAD: begin
                    if (half_end) begin
                        sw_load  <= 1'b0;
                        sw_sdata <= 1'b0;
                        done     <= 1'b1;
                        state_q  <= SH_IDLE;
                    end
                end
                default: state_q <= SH_IDLE;
            endcase
        end
    end
endmodule // route_shifter

// file: rtl/crosspoint_switch_setup_port.sv
// APB register front end for the 4x4 clock crosspoint switch setup
//
// Overview of operation
// - status bit 0 reads 0 while busy, 1 when a command can be taken.
// - readback shows each output's source input, output 3 highest field.
// - two-bit selection code equals the input number, 0 through 3.
// - one write-data transfer reroutes exactly one output, others unchanged.
// - write-data bits 5:4 pick the output to reprogram.
// - write-data bits 1:0 hold the input number, readable and writable.
// - writing 0b01 to request starts transfer; reads in progress, self-clears.
`timescale 1ns/100ps
`include "xpoint_cfg.svh"

module crosspoint_switch_setup_port #(
    parameter int HALF_CYCLES = (`XP_SCLK_HALF_NS + `XP_CLK_PERIOD_NS - 1) / `XP_CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sw_sclk,
    output logic             sw_sdata,
    output logic             sw_load
);
    import xpoint_pkg::*;

    apb_req_s   req;
    route_cmd_s wr_data_q;
    logic [7:0] route_q;
    logic       pending_q;
    logic       ready_q;
    logic       sh_busy;
    logic       sh_done;
    logic [31:0] rd_mux;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    wire hit_ctrl   = (req.paddr == 12'(`XP_IDX_CTRL)     << `XP_ADDR_SHIFT);
    wire hit_status = (req.paddr == 12'(`XP_IDX_STATUS)   << `XP_ADDR_SHIFT);
    wire hit_rb     = (req.paddr == 12'(`XP_IDX_READBACK) << `XP_ADDR_SHIFT);
    wire hit_wr     = (req.paddr == 12'(`XP_IDX_WRITE)    << `XP_ADDR_SHIFT);
    wire mapped     = hit_ctrl | hit_status | hit_rb | hit_wr;
    wire setup      = req.psel & ~req.penable;
    wire access     = req.psel & req.penable & ce;
    wire wr_en      = access & req.pwrite & mapped;
    wire busy       = pending_q | sh_busy;

    wire [`XP_SEL_W-1:0] req_field = req.pwdata[`XP_REQ_MSB:`XP_REQ_LSB];
    // new data and requests are dropped while busy so a transfer never sees its data move
    wire load_wr   = wr_en & hit_wr & ~busy;
    wire start_req = wr_en & hit_ctrl & ~busy & (req_field == `XP_REQ_WRITE);
    wire [`XP_SEL_W-1:0] ctrl_rd = busy ? `XP_REQ_WRITE : `XP_REQ_NONE;

    // every access answers in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = req.psel & req.penable & ~mapped;

    always_comb begin
        rd_mux = `XP_WORD_ZERO;
        if (hit_ctrl) begin
            rd_mux[`XP_REQ_MSB:`XP_REQ_LSB] = ctrl_rd;
        end
        if (hit_status) begin
            rd_mux[`XP_RDY_BIT] = ready_q;
        end
        if (hit_rb) begin
            rd_mux[7:0] = route_q;
        end
        if (hit_wr) begin
            rd_mux[`XP_OUT_SEL_MSB:`XP_OUT_SEL_LSB] = wr_data_q.out_sel;
            rd_mux[`XP_IN_SEL_MSB:`XP_IN_SEL_LSB]   = wr_data_q.in_sel;
        end
    end

    // read data is caught in the setup cycle so it can come from a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= `XP_WORD_ZERO;
        end else if (ce && setup) begin
            prdata <= req.pwrite ? `XP_WORD_ZERO : rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_data_q <= '{out_sel: `XP_SEL_ZERO, in_sel: `XP_SEL_ZERO};
        end else if (load_wr) begin
            wr_data_q.out_sel <= req.pwdata[`XP_OUT_SEL_MSB:`XP_OUT_SEL_LSB];
            wr_data_q.in_sel  <= req.pwdata[`XP_IN_SEL_MSB:`XP_IN_SEL_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pending_q <= 1'b0;
        end else if (ce) begin
            pending_q <= start_req;
        end
    end

    // ready leaves reset low and rises one cycle later once idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_q <= 1'b0;
        end else if (ce) begin
            ready_q <= ~busy & ~start_req;
        end
    end

    // only the addressed field is replaced; code value is the input number
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            route_q <= `XP_ROUTE_RESET;
        end else if (ce && sh_done) begin
            route_q[wr_data_q.out_sel * `XP_SEL_W +: `XP_SEL_W] <= wr_data_q.in_sel;
        end
    end

    route_shifter #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_shifter (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .start    (pending_q),
        .cmd      (wr_data_q),
        .busy     (sh_busy),
        .done     (sh_done),
        .sw_sclk  (sw_sclk),
        .sw_sdata (sw_sdata),
        .sw_load  (sw_load)
    );
endmodule // crosspoint_switch_setup_port

// file: dv/xpoint_sva.sv
// pin-level assertions for the crosspoint setup port
`timescale 1ns/100ps
module xpoint_sva (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sw_sclk,
    input wire logic        sw_load
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire rd_setup = psel && !penable && !pwrite && ce;
    wire access   = psel && penable;
    wire mapped   = paddr inside {12'h080, 12'h084, 12'h088, 12'h08c};
    a_status_fmt: assert property (rd_setup && paddr == 12'h084 |=> prdata[31:1] == 31'h0)
        else $error("status read has bits above ready");
    a_rdbk_fmt: assert property (rd_setup && paddr == 12'h088 |=> prdata[31:8] == 24'h0)
        else $error("readback wider than four fields");
    a_wdata_fmt: assert property (rd_setup && paddr == 12'h08c |=> prdata[31:6] == 26'h0 && prdata[3:2] == 2'h0)
        else $error("write data reserved bits set");
    a_ctrl_fmt: assert property (rd_setup && paddr == 12'h080 |=> prdata[31:1] == 31'h0)
        else $error("control shows an unknown code");
    a_unmapped_err: assert property (access && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (access && mapped |-> !pslverr)
        else $error("mapped access flagged");
    a_zero_wait: assert property (access |-> pready)
        else $error("access phase stalled");
    a_load_quiet: assert property ($rose(sw_load) |-> !sw_sclk && $past(!sw_load))
        else $error("load strobe during clocking");
endmodule // xpoint_sva

bind crosspoint_switch_setup_port xpoint_sva u_xpoint_sva (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_sclk(sw_sclk), .sw_load(sw_load));

// file: dv/xpoint_switch_model.sv
// behavioural switch chip: shifts in one output/input pair and latches it
`timescale 1ns/100ps
module xpoint_switch_model (
    input  wire logic       sw_sclk,
    input  wire logic       sw_sdata,
    input  wire logic       sw_load,
    output logic      [7:0] route_q
);
    logic [3:0] shift_q;
    initial route_q = 8'h00;
    always @(posedge sw_sclk) shift_q <= {shift_q[2:0], sw_sdata};
    // only the addressed output moves, the rest keep their source
    always @(posedge sw_load) route_q[shift_q[3:2]*2 +: 2] <= shift_q[1:0];
endmodule // xpoint_switch_model

// file: dv/crosspoint_switch_setup_port_tb.sv
// self-checking bench for the crosspoint setup port
`timescale 1ns/100ps
module crosspoint_switch_setup_port_tb;
    localparam logic [11:0] A_CTRL = 12'h080, A_STAT = 12'h084, A_RDBK = 12'h088, A_WDAT = 12'h08c;
    logic        clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, wd;
    logic        pready, pslverr, sw_sclk, sw_sdata, sw_load, err;
    logic [7:0]  chip_route, exp_route;
    logic [1:0]  o, inp;
    int          n_errors = 0, checks = 0, n;
    always #5 clk = ~clk;
    crosspoint_switch_setup_port #(.HALF_CYCLES(1)) u_crosspoint_switch_setup_port (.clk(clk), .sys_rst(sys_rst),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sw_sclk(sw_sclk), .sw_sdata(sw_sdata), .sw_load(sw_load));
    xpoint_switch_model u_xpoint_switch_model (.sw_sclk(sw_sclk), .sw_sdata(sw_sdata), .sw_load(sw_load),
        .route_q(chip_route));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask
    task automatic summarize;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        // ready leaves reset low and only rises at the first edge after release
        @(posedge clk);
        rdchk(A_STAT, 32'h1);
        rdchk(A_RDBK, 32'h0);
        rdchk(A_CTRL, 32'h0);
        apb(1'b1, A_STAT, 32'h0);
        rdchk(A_STAT, 32'h1);
        rdchk(12'h090, 32'h0);
        cmp({31'h0, err}, 32'h1);
        rdchk(A_WDAT, 32'h0);
        cmp({31'h0, err}, 32'h0);
        // a write while the clock enable is low must leave no trace
        ce <= 1'b0;
        apb(1'b1, A_WDAT, 32'h31);
        ce <= 1'b1;
        rdchk(A_WDAT, 32'h0);
        $display("test reset_map done");
        exp_route = 8'h00;
        // fifth pass revisits output 0 so untouched fields can be seen holding
        for (int k = 0; k < 5; k++) begin
            o = 2'(k % 4);
            inp = 2'((k + k / 4 + 1) % 4);
            wd = {26'h0, o, 2'h0, inp};
            apb(1'b1, A_WDAT, wd | 32'hcc);
            rdchk(A_WDAT, wd);
            apb(1'b1, A_CTRL, 32'h1);
            rdchk(A_CTRL, 32'h1);
            rdchk(A_STAT, 32'h0);
            apb(1'b1, A_WDAT, 32'h0);
            n = 0;
            do begin
                apb(1'b0, A_STAT, 32'h0);
                n++;
            end while (rd !== 32'h1 && n < 30);
            cmp(rd, 32'h1);
            exp_route[2*o +: 2] = inp;
            rdchk(A_WDAT, wd);
            rdchk(A_CTRL, 32'h0);
            rdchk(A_RDBK, {24'h0, exp_route});
            cmp({24'h0, chip_route}, {24'h0, exp_route});
        end
        $display("test route_all done");
        summarize();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule // crosspoint_switch_setup_port_tb
